// ### sadc_pkg.sv
// constants and types shared by the converter mode controller
// assumes a single 40 MHz clock domain and a 32-bit AXI4-Lite register port
package sadc_pkg;

  // register byte offsets
  localparam logic [5:0] CTRL_OFS     = 6'h00;
  localparam logic [5:0] STAT_OFS     = 6'h04;
  localparam logic [5:0] RES_BASE_OFS = 6'h20;

  // control register fields
  localparam int SEL_LSB   = 0;
  localparam int MODE_LSB  = 3;
  localparam int START_BIT = 6;
  localparam int RES10_BIT = 7;
  localparam int VREF_BIT  = 8;
  localparam int SWP_LSB   = 9;
  localparam int CKS_LSB   = 11;
  localparam int SH_BIT    = 13;
  localparam int CTRL_W    = 14;
  localparam logic [13:0] CTRL_RST = 14'h0000;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_CHAN_LSB = 4;

  // conversion lengths in conversion-clock cycles
  localparam logic [5:0] CYC_8_PLAIN  = 6'h31;
  localparam logic [5:0] CYC_10_PLAIN = 6'h3b;
  localparam logic [5:0] CYC_8_SH     = 6'h1c;
  localparam logic [5:0] CYC_10_SH    = 6'h21;

  // conversion clock select codes
  localparam logic [1:0] CKS_DIV1 = 2'h0;
  localparam logic [1:0] CKS_DIV2 = 2'h1;
  localparam logic [1:0] CKS_DIV4 = 2'h2;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MODE_ONE  = 3'h0,
    MODE_REP  = 3'h1,
    MODE_SSW  = 3'h2,
    MODE_RSW0 = 3'h3,
    MODE_RSW1 = 3'h4
  } sadc_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CONV = 2'h1,
    ST_DONE = 2'h3
  } sadc_state_e;

endpackage

// ### sadc_clk_div.sv
// conversion clock tick generator
// assumes the source clock is the module clock itself
`timescale 1ns/1ps
`default_nettype none
module sadc_clk_div (
  input  wire logic       aclk,    // source clock
  input  wire logic       aresetn, // sync reset, active low
  input  wire logic [1:0] cks,     // divide select
  output logic            tick     // one conversion-clock cycle
);

  typedef struct packed {
    logic [1:0] cnt;
  } sadc_div_s;

  sadc_div_s q_r;
  sadc_div_s q_nxt;

  always_comb begin
    q_nxt     = q_r;
    q_nxt.cnt = q_r.cnt + 2'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // source, half or quarter rate
  always_comb begin
    case (cks)
      sadc_pkg::CKS_DIV1: tick = 1'b1;
      sadc_pkg::CKS_DIV2: tick = q_r.cnt[0];
      sadc_pkg::CKS_DIV4: tick = &q_r.cnt;
      default:            tick = &q_r.cnt;
    endcase
  end

endmodule
`default_nettype wire

// ### sadc_res_mem.sv
// per-pin result store, two byte lanes, registered read
// assumes one writer (the sequencer) and one reader (the bus)
`timescale 1ns/1ps
`default_nettype none
module sadc_res_mem (
  input  wire logic       aclk,    // clock
  input  wire logic       aresetn, // sync reset, active low
  input  wire logic [1:0] we,      // lane 0 low byte, lane 1 top bits
  input  wire logic [2:0] waddr,   // pin number
  input  wire logic [9:0] wdata,   // result
  input  wire logic [2:0] raddr,   // read pin number
  output logic      [9:0] rdata    // registered read data
);

  typedef struct packed {
    logic [7:0][9:0] mem;
    logic [9:0]      rd;
  } sadc_mem_s;

  sadc_mem_s q_r;
  sadc_mem_s q_nxt;

  always_comb begin
    q_nxt    = q_r;
    q_nxt.rd = q_r.mem[raddr];
    if (we[0]) begin
      q_nxt.mem[waddr][7:0] = wdata[7:0];
    end
    if (we[1]) begin
      q_nxt.mem[waddr][9:8] = wdata[9:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rdata = q_r.rd;

endmodule
`default_nettype wire

// ### sadc_ctrl.sv
// mode controller of an eight-input successive-approximation converter
// assumes an analog core on the same clock that presents its result
// while ana_busy is high, and an AXI4-Lite master on the register side
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////
module sadc_ctrl (
  input  wire logic        aclk,           // 40 MHz clock
  input  wire logic        aresetn,        // sync reset, active low
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [5:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // byte strobes
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  output logic      [1:0]  s_axi_bresp,    // write response
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  input  wire logic [5:0]  s_axi_araddr,   // read address
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  output logic      [31:0] s_axi_rdata,    // read data
  output logic      [1:0]  s_axi_rresp,    // read response
  input  wire logic [9:0]  ana_result,     // analog core result
  output logic      [2:0]  ana_chan,       // pin being converted
  output logic             ana_busy,       // conversion in progress
  output logic             ana_res10,      // 10-bit resolution
  output logic             ana_sh_en,      // sample-and-hold on
  output logic             vref_connect,   // ladder joined to reference
  output logic             conv_irq        // end-of-conversion pulse
);

  //////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [13:0]          ctrl;
    sadc_pkg::sadc_state_e st;
    logic [5:0]           cyc;
    logic [2:0]           chan;
    logic [1:0]           emph;
    logic [2:0]           other;
    logic                 in_other;
    logic                 aw_ok;
    logic [5:0]           awaddr;
    logic                 w_ok;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rpend;
    logic [5:0]           araddr;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } sadc_ctrl_s;

  sadc_ctrl_s q_r;
  sadc_ctrl_s q_nxt;

  logic                  tick;
  logic [9:0]            mem_rd;
  logic [1:0]            mem_we;
  logic                  irq_now;
  logic [5:0]            len;
  logic [2:0]            sel;
  logic [1:0]            swp;
  logic [2:0]            last_pin;
  logic                  res10;
  logic                  sh;
  logic                  start;
  sadc_pkg::sadc_mode_e  mode;
  logic [13:0]           wr_ctrl;
  logic                  wr_go;

  assign sel      = q_r.ctrl[sadc_pkg::SEL_LSB +: 3];
  assign swp      = q_r.ctrl[sadc_pkg::SWP_LSB +: 2];
  assign res10    = q_r.ctrl[sadc_pkg::RES10_BIT];
  assign sh       = q_r.ctrl[sadc_pkg::SH_BIT];
  assign start    = q_r.ctrl[sadc_pkg::START_BIT];
  assign mode     = sadc_pkg::sadc_mode_e'(q_r.ctrl[sadc_pkg::MODE_LSB +: 3]);
  // groups of 2, 4, 6 or 8 pins end at 1, 3, 5 or 7
  assign last_pin = {swp, 1'b1};

  //////////////////////////////////////////////////////////////////////
  // helpers

  sadc_clk_div i_sadc_clk_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cks     (q_r.ctrl[sadc_pkg::CKS_LSB +: 2]),
    .tick    (tick)
  );

  // byte lanes follow the resolution
  // the odd lane is left alone at 8 bits, so an older top pair survives
  assign mem_we = (q_r.st == sadc_pkg::ST_DONE) ? {res10, 1'b1} : 2'h0;

  sadc_res_mem i_sadc_res_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (mem_we),
    .waddr   (q_r.chan),
    .wdata   (ana_result),
    .raddr   (s_axi_araddr[4:2]),
    .rdata   (mem_rd)
  );

  // lengths count conversion-clock ticks, not aclk cycles
  always_comb begin
    case ({sh, res10})
      2'h0:    len = sadc_pkg::CYC_8_PLAIN;
      2'h1:    len = sadc_pkg::CYC_10_PLAIN;
      2'h2:    len = sadc_pkg::CYC_8_SH;
      default: len = sadc_pkg::CYC_10_SH;
    endcase
  end

  // control word as a pending write would leave it
  always_comb begin
    wr_ctrl = q_r.ctrl;
    if (q_r.wstrb[0]) begin
      wr_ctrl[7:0] = q_r.wdata[7:0];
    end
    if (q_r.wstrb[1]) begin
      wr_ctrl[13:8] = q_r.wdata[13:8];
    end
  end

  assign wr_go = q_r.aw_ok && q_r.w_ok && !q_r.bvalid;

  // aw and w are parked for one cycle after they are taken; the write
  // lands on the next edge together with bvalid, so software sees the
  // new control word two cycles after the later of the two handshakes.
  // a stop write lands at once: the cut pin keeps its old result and
  // every pin finished earlier keeps the one it had.

  //////////////////////////////////////////////////////////////////////
  // sequencer and bus

  always_comb begin
    q_nxt   = q_r;
    irq_now = 1'b0;

    case (q_r.st)
      sadc_pkg::ST_IDLE: begin
        // pin number kept so status still shows the last one
        q_nxt.cyc = 6'h00;
      end
      sadc_pkg::ST_CONV: begin
        // first tick may lag entry by up to three cycles (free divider)
        if (tick) begin
          q_nxt.cyc = q_r.cyc + 6'h01;
          if (q_r.cyc == len - 6'h01) begin
            q_nxt.st = sadc_pkg::ST_DONE;
          end
        end
      end
      sadc_pkg::ST_DONE: begin
        // result written this cycle; choose next pin
        q_nxt.cyc = 6'h00;
        q_nxt.st  = sadc_pkg::ST_CONV;
        case (mode)
          sadc_pkg::MODE_REP: begin
            q_nxt.chan = q_r.chan;
          end
          sadc_pkg::MODE_SSW: begin
            if (q_r.chan == last_pin) begin
              q_nxt.st                          = sadc_pkg::ST_IDLE;
              q_nxt.ctrl[sadc_pkg::START_BIT]   = 1'b0;
              irq_now                           = 1'b1;
            end else begin
              q_nxt.chan = q_r.chan + 3'h1;
            end
          end
          sadc_pkg::MODE_RSW0: begin
            q_nxt.chan = (q_r.chan == last_pin) ? 3'h0 : q_r.chan + 3'h1;
          end
          sadc_pkg::MODE_RSW1: begin
            // emphasised pins 0..swp, then one of the others
            if (q_r.in_other) begin
              q_nxt.in_other = 1'b0;
              q_nxt.emph     = 2'h0;
              q_nxt.chan     = 3'h0;
              q_nxt.other    = (q_r.other == 3'h7) ? {1'b0, swp} + 3'h1 : q_r.other + 3'h1;
            end else if (q_r.emph == swp) begin
              q_nxt.in_other = 1'b1;
              q_nxt.chan     = q_r.other;
            end else begin
              q_nxt.emph = q_r.emph + 2'h1;
              q_nxt.chan = {1'b0, q_r.emph + 2'h1};
            end
          end
          default: begin
            // one-shot, also taken for unused mode codes
            q_nxt.st                        = sadc_pkg::ST_IDLE;
            q_nxt.ctrl[sadc_pkg::START_BIT] = 1'b0;
            irq_now                         = 1'b1;
          end
        endcase
      end
      default: begin
        q_nxt.st = sadc_pkg::ST_IDLE;
      end
    endcase

    // write address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      q_nxt.aw_ok  = 1'b1;
      q_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      q_nxt.w_ok  = 1'b1;
      q_nxt.wdata = s_axi_wdata;
      q_nxt.wstrb = s_axi_wstrb;
    end
    if (q_r.bvalid && s_axi_bready) begin
      q_nxt.bvalid = 1'b0;
    end

    // a software write overrides a same-cycle hardware clear of start
    if (wr_go) begin
      q_nxt.aw_ok  = 1'b0;
      q_nxt.w_ok   = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp  = sadc_pkg::RESP_OKAY;
      if (q_r.awaddr[5:2] == sadc_pkg::CTRL_OFS[5:2]) begin
        q_nxt.ctrl = wr_ctrl;
        if (!wr_ctrl[sadc_pkg::START_BIT]) begin
          q_nxt.st = sadc_pkg::ST_IDLE;
        end else if (!start) begin
          // only the zero-to-one change starts a run
          q_nxt.st       = sadc_pkg::ST_CONV;
          q_nxt.cyc      = 6'h00;
          q_nxt.emph     = 2'h0;
          q_nxt.in_other = 1'b0;
          q_nxt.other    = {1'b0, wr_ctrl[sadc_pkg::SWP_LSB +: 2]} + 3'h1;
          // sweeps open at pin 0; every other code, the spare ones
          // included, runs as a single-pin mode on the selected input
          if (wr_ctrl[sadc_pkg::MODE_LSB +: 3] == sadc_pkg::MODE_SSW ||
              wr_ctrl[sadc_pkg::MODE_LSB +: 3] == sadc_pkg::MODE_RSW0 ||
              wr_ctrl[sadc_pkg::MODE_LSB +: 3] == sadc_pkg::MODE_RSW1) begin
            q_nxt.chan = 3'h0;
          end else begin
            q_nxt.chan = wr_ctrl[sadc_pkg::SEL_LSB +: 3];
          end
        end
      end else begin
        q_nxt.bresp = sadc_pkg::RESP_SLVERR;
      end
    end

    // read: result memory answers one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready) begin
      q_nxt.rpend  = 1'b1;
      q_nxt.araddr = s_axi_araddr;
    end
    // results, control and status are the only readable words; any
    // other address answers zero with an error response
    if (q_r.rpend) begin
      q_nxt.rpend  = 1'b0;
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp  = sadc_pkg::RESP_OKAY;
      q_nxt.rdata  = 32'h0000_0000;
      if (q_r.araddr[5]) begin
        q_nxt.rdata[9:0] = mem_rd;
      end else if (q_r.araddr[5:2] == sadc_pkg::CTRL_OFS[5:2]) begin
        q_nxt.rdata[13:0] = q_r.ctrl;
      end else if (q_r.araddr[5:2] == sadc_pkg::STAT_OFS[5:2]) begin
        q_nxt.rdata[sadc_pkg::STAT_BUSY_BIT]     = (q_r.st != sadc_pkg::ST_IDLE);
        q_nxt.rdata[sadc_pkg::STAT_CHAN_LSB +: 3] = q_r.chan;
      end else begin
        q_nxt.rresp = sadc_pkg::RESP_SLVERR;
      end
    end
    if (q_r.rvalid && s_axi_rready) begin
      q_nxt.rvalid = 1'b0;
    end
  end

  // reset clears control, sequencer and any parked bus item
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r      <= '0;
      q_r.ctrl <= sadc_pkg::CTRL_RST;
      q_r.st   <= sadc_pkg::ST_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign s_axi_awready = !q_r.aw_ok && !q_r.bvalid;
  assign s_axi_wready  = !q_r.w_ok && !q_r.bvalid;
  assign s_axi_bvalid  = q_r.bvalid;
  assign s_axi_bresp   = q_r.bresp;
  // one read at a time keeps the memory port free
  assign s_axi_arready = !q_r.rpend && !q_r.rvalid;
  assign s_axi_rvalid  = q_r.rvalid;
  assign s_axi_rdata   = q_r.rdata;
  assign s_axi_rresp   = q_r.rresp;

  assign ana_chan     = q_r.chan;
  assign ana_busy     = (q_r.st != sadc_pkg::ST_IDLE);
  assign ana_res10    = res10;
  assign ana_sh_en    = sh;
  // cleared bit isolates the ladder and stops its current
  assign vref_connect = q_r.ctrl[sadc_pkg::VREF_BIT];
  // decode of the done cycle, so the pulse can never stretch
  assign conv_irq     = irq_now;

endmodule
`default_nettype wire

// ### sadc_ctrl_monitor.sv
// port assertions for the converter mode controller
// assumes one clock domain; bound into every sadc_ctrl
`timescale 1ns/1ps
`default_nettype none
module sadc_ctrl_monitor (
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // reset, low
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic [1:0]  s_axi_bresp,   // b resp
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic [31:0] s_axi_rdata,   // r data
  input wire logic [2:0]  ana_chan,      // pin
  input wire logic        ana_busy,      // running
  input wire logic        ana_res10,     // 10-bit
  input wire logic        ana_sh_en,     // hold on
  input wire logic        vref_connect,  // ladder joined
  input wire logic        conv_irq       // end pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [8:0] cnt_r;
  logic [2:0] chan_r;
  logic [8:0] len;
  ////////
  // one cycle of slack: the count restarts when the pin changes on entry
  assign len = {3'h0, ana_sh_en ? (ana_res10 ? sadc_pkg::CYC_10_SH : sadc_pkg::CYC_8_SH)
                               : (ana_res10 ? sadc_pkg::CYC_10_PLAIN : sadc_pkg::CYC_8_PLAIN)};
  always_ff @(posedge aclk) begin
    chan_r <= ana_chan;
    if (!aresetn || !ana_busy || ana_chan != chan_r) cnt_r <= 9'h000;
    else cnt_r <= cnt_r + 9'h001;
  end
  ////////
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready ##1 s_axi_rvalid)
    else $error("read answer late");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  irq_pulse_a: assert property (conv_irq |=> !conv_irq && !ana_busy)
    else $error("interrupt not a single final pulse");
  irq_run_a: assert property (conv_irq |-> $past(ana_busy))
    else $error("interrupt outside a run");
  conv_len_a: assert property (conv_irq |-> cnt_r + 9'h001 >= len && cnt_r <= 9'h0f8)
    else $error("conversion length wrong");
  vref_write_a: assert property ($changed(vref_connect) |-> $rose(s_axi_bvalid))
    else $error("ladder switch without write");
  start_write_a: assert property ($rose(ana_busy) |-> $rose(s_axi_bvalid))
    else $error("conversion began without write");
  cover property (conv_irq);
  cover property ($fell(ana_busy) && !$past(conv_irq));
  cover property ($rose(vref_connect));
endmodule
bind sadc_ctrl sadc_ctrl_monitor i_sadc_ctrl_monitor (.*);
`default_nettype wire

// ### sadc_ana_model.sv
// analog core stand-in for the eight input pins
// assumes same clock as the controller
`timescale 1ns/1ps
`default_nettype none
module sadc_ana_model (
  input  wire logic       aclk,      // clock
  input  wire logic [2:0] ana_chan,  // pin asked for
  input  wire logic       ana_busy,  // run active
  input  wire logic       ana_res10, // resolution
  output logic      [9:0] ana_result // pin level
);
  logic [9:0] idle_r = 10'h155;
  // outside a run the level toggles so a stale sample is caught
  always @(posedge aclk) idle_r <= ~idle_r;
  assign ana_result = ana_busy ? {~ana_res10, ana_res10, ana_chan, 2'h1, ana_chan} : idle_r;
endmodule
`default_nettype wire

// ### test_sar_adc_mode_control.sv
// self-checking bench for the converter mode controller
// assumes the analog stand-in and the bound monitor
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_mode_control;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        ana_busy, ana_res10, ana_sh_en, vref_connect, conv_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [9:0]  ana_result;
  logic [2:0]  ana_chan;
  logic [33:0] exp_q[$];
  logic [33:0] got;
  logic [2:0]  chan_log[$];
  logic [9:0]  mem[8];
  logic [31:0] lfsr = 32'h020591b4;
  int          bad_count = 0, compares = 0, cyc = 0, irq_n = 0, run_len = 0;

  always #12.5 aclk = ~aclk;
  sadc_ctrl i_sadc_ctrl (.*);
  sadc_ana_model i_sadc_ana_model (.*);
  ////////
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] ctl(input logic [2:0] sel, md, input logic r10, sh, input logic [1:0] swp, cks);
    return {18'h0, sh, cks, swp, 1'b1, r10, 1'b1, md, sel};
  endfunction
  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic go(input logic [31:0] w);
    chan_log.delete();
    run_len = 0;
    irq_n = 0;
    wr(sadc_pkg::CTRL_OFS, w & 32'hffffffbf, sadc_pkg::RESP_OKAY);
    wr(sadc_pkg::CTRL_OFS, w, sadc_pkg::RESP_OKAY);
  endtask
  ////////
  always @(posedge aclk) begin
    cyc++;
    if (ana_busy === 1'b1) run_len++;
    if (conv_irq === 1'b1) irq_n++;
    if (ana_busy === 1'b1 && (chan_log.size() == 0 || chan_log[$] !== ana_chan)) chan_log.push_back(ana_chan);
    if ((s_axi_bvalid & s_axi_bready | s_axi_rvalid & s_axi_rready) === 1'b1) begin
      got = exp_q.pop_front();
      if (s_axi_bvalid === 1'b1) check(s_axi_bresp === got[33:32], "write response");
      else check({s_axi_rresp, s_axi_rdata} === got, "read data");
    end
    if (cyc == 20000) begin
      check(1'b0, "timeout");
      finish_test();
    end
  end
  ////////
  initial begin
    logic [2:0]  p;
    logic [9:0]  lv;
    logic [31:0] w;
    logic        r10, sh;
    int          len, d;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) mem[i] = 10'h000;
    rd(sadc_pkg::CTRL_OFS, 32'h0, sadc_pkg::RESP_OKAY);
    rd(6'h10, 32'h0, sadc_pkg::RESP_SLVERR);
    wr(sadc_pkg::STAT_OFS, 32'hffff, sadc_pkg::RESP_SLVERR);
    $display("test registers done");
    lfsr = next_rand(lfsr);
    p = lfsr[2:0];
    for (int k = 0; k < 7; k++) begin
      r10 = k < 4 && k[0];
      sh = k < 4 && k[1];
      d = k < 4 ? 1 : k == 4 ? 2 : 4;
      len = sh ? (r10 ? 33 : 28) : (r10 ? 59 : 49);
      w = ctl(p, k == 6 ? 3'h5 : 3'h0, r10, sh, 2'h0, k < 4 ? 2'h0 : 2'(k - 3));
      go(w);
      check(vref_connect === 1'b1, "ladder joined");
      while (ana_busy === 1'b1) @(posedge aclk);
      check(irq_n === 1 && (d == 1 ? run_len == len + 1 : run_len > (len - 1) * d && run_len <= (len + 1) * d),
            "one-shot length");
      lv = level_of(p, r10);
      mem[p][7:0] = lv[7:0];
      if (r10) mem[p][9:8] = lv[9:8];
      rd(sadc_pkg::RES_BASE_OFS + {1'b0, p, 2'h0}, {22'h0, mem[p]}, sadc_pkg::RESP_OKAY);
      rd(sadc_pkg::CTRL_OFS, w & 32'hffffffbf, sadc_pkg::RESP_OKAY);
    end
    $display("test one-shot done");
    lfsr = next_rand(lfsr);
    p = lfsr[2:0];
    w = ctl(p, 3'h1, 1'b1, 1'b1, 2'h0, 2'h0);
    go(w);
    repeat (150) @(posedge aclk);
    wr(sadc_pkg::CTRL_OFS, w & 32'hffffffbf, sadc_pkg::RESP_OKAY);
    check(ana_busy === 1'b0 && irq_n === 0 && chan_log.size() == 1 && run_len > 140, "repeat run");
    mem[p] = level_of(p, 1'b1);
    rd(sadc_pkg::RES_BASE_OFS + {1'b0, p, 2'h0}, {22'h0, mem[p]}, sadc_pkg::RESP_OKAY);
    wr(sadc_pkg::CTRL_OFS, 32'h0, sadc_pkg::RESP_OKAY);
    check(vref_connect === 1'b0, "ladder isolated");
    $display("test repeat done");
    for (int m = 2; m < 5; m++) begin
      w = ctl(3'h0, 3'(m), 1'b0, 1'b1, m == 2 ? 2'h3 : 2'h1, 2'h0);
      go(w);
      if (m == 2) while (ana_busy === 1'b1) @(posedge aclk);
      else begin
        repeat (300) @(posedge aclk);
        wr(sadc_pkg::CTRL_OFS, w & 32'hffffffbf, sadc_pkg::RESP_OKAY);
      end
      check(irq_n === (m == 2 ? 1 : 0) && chan_log.size() >= 8, "sweep end");
      for (int i = 0; i < 8; i++)
        check(chan_log[i] === 3'(m == 2 ? i : m == 3 ? i % 4 : i % 3 < 2 ? i % 3 : 2 + i / 3), "sweep order");
      $display("test sweep mode %0d done", m);
    end
    finish_test();
  end
  function automatic logic [9:0] level_of(input logic [2:0] q, input logic r);
    return {~r, r, q, 2'h1, q};
  endfunction
endmodule
`default_nettype wire
